// ---- rtl/dats_supervisor.sv ----
/*
 Drive alarm trip supervisor with AXI4-Lite register slave.
 Assumes condition inputs synchronous to clk and a millisecond time base from clk.
*/
// Behaviour
// - Trip when slow rotor and stall current persist beyond stall delay.
// - Trip 15 s after thermistor loop exceeds 1800 ohms; no disable.
// - Trip 0.75 s after heatsink over-temperature flag.
// - Large frames also raise heatsink alarm below 150 VAC fan supply.
// - Any shorted digital output raises alarm and forces all outputs low.
// - Shorted 24V user supply forces outputs low and raises alarm.
// - With short trip disabled the drive keeps running.
// - Short trip enable resets enabled; disabled suppresses that trip.
// - Invalid reference data raises bad-reference alarm after 1.5 s.
// - Bad-reference alarm only evaluated in reference receiver port role.
// - Bad-reference trip enable resets disabled; trips only when enabled.
// - With zero-reference interlock on, refuse start on nonzero reference.
// - Contactor lockout trips 3 s after no sync or refused start.
// - User alarm trips after 0.5 s; its source resets disconnected.
// - Network card watchdog timeout ORed into user alarm.
// - Lock to 45-65 Hz supply after 750 ms, then keep tracking.
// - Sync loss checked only while running; at start gives lockout.
// - Phase loss below 75% rated; two phases always, third at start.
// - Running phase loss trips after 2 s ride-through, else resumes.
// - Hold stator current demand at zero during supply loss.
// - Phase loss at start energises contactor, inhibits current, trips 3 s.
`timescale 1ns/100ps
`include "dats_cfg.svh"
module dats_supervisor #(
	parameter int MS_TICK_CYCLES = `DATS_CLK_HZ / 1000000 * `DATS_TICK_US
) (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [15:0] rotorSpeed,
	input  wire logic [15:0] statorCurrent,
	input  wire logic [15:0] thermOhms,
	input  wire logic [1:0]  sinkHot,
	input  wire logic        largeFrame,
	input  wire logic [15:0] fanVolts,
	input  wire logic [6:0]  doutShort,
	input  wire logic        userSupplyShort,
	input  wire logic [6:0]  doutRequest,
	input  wire logic        refDataInvalid,
	input  wire logic        startRequest,
	input  wire logic        extRefNonzero,
	input  wire logic        userAlarmPin,
	input  wire logic        netCardPresent,
	input  wire logic        netWatchdogTimeout,
	input  wire logic        supplyPresent,
	input  wire logic [7:0]  supplyFreqHz,
	input  wire logic [15:0] el1Volts,
	input  wire logic [15:0] el2Volts,
	input  wire logic [15:0] el3Volts,
	output logic [6:0]       doutDrive,
	output logic             tripOut,
	output logic [3:0]       tripCause,
	output logic             currentInhibit,
	output logic             contactorOn,
	output logic             runActive
);
	localparam int NAL = 10;
	logic [5:0]           ctrl_r;
	logic [15:0]          zeroSpeedLvl_r;
	logic [15:0]          stallCurLvl_r;
	logic [15:0]          stallDelay_r;
	logic [15:0]          supply_rated_volts_r;
	logic                 trip_r;
	logic [3:0]           cause_r;
	logic [31:0]          tickCnt_r;
	logic                 msTick;
	logic [15:0]          syncCnt_r;
	logic                 syncAcquired;
	logic                 freqInRange;
	dats_pkg::run_type    runState_r;
	logic [NAL-1:0]       alarmCond;
	logic [NAL-1:0]       alarmExpired;
	logic [NAL-1:0]       alarmEnabled;
	logic [15:0]          alarmDelay [NAL];
	logic [15:0]          timerCnt_r [NAL];
	logic [NAL-1:0]       fire;
	logic [3:0]           cause_nxt;
	logic                 anyShort;
	logic                 lossLive;
	logic                 lossAny;
	logic                 zeroRefViolation;
	logic                 userAlarmIn;
	logic [17:0]          lossLimit;
	logic                 awHeld_r;
	logic                 wHeld_r;
	logic [7:0]           awAddr_r;
	logic [31:0]          wData_r;
	logic [3:0]           wStrb_r;
	logic                 doWrite;
	logic                 clearReq;
	logic                 output_short_trip_en;
	logic                 refTripEn;
	logic                 zeroRefStartEn;
	logic                 userAlarmSel;
	logic [1:0]           serial_port_role;
	logic                 ref_share_receiver_mode;

	function automatic logic [15:0] merge16(logic [15:0] old, logic [31:0] d, logic [3:0] s);
		merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	assign output_short_trip_en    = ctrl_r[`DATS_CTRL_SHORT];
	assign refTripEn               = ctrl_r[`DATS_CTRL_REF];
	assign zeroRefStartEn          = ctrl_r[`DATS_CTRL_ZREF];
	assign userAlarmSel            = ctrl_r[`DATS_CTRL_USER];
	assign serial_port_role        = ctrl_r[`DATS_CTRL_ROLE +: 2];
	assign ref_share_receiver_mode = (serial_port_role == `DATS_ROLE_RECV);

	// AXI4-Lite write channel
	assign s_axi_awready = !awHeld_r && !s_axi_bvalid;
	assign s_axi_wready  = !wHeld_r && !s_axi_bvalid;
	assign doWrite       = awHeld_r && wHeld_r && !s_axi_bvalid;
	assign clearReq      = doWrite && (awAddr_r == `DATS_REG_CLEAR) && wStrb_r[0] && wData_r[0];

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			awHeld_r <= 1'b0;
			wHeld_r <= 1'b0;
			awAddr_r <= 8'h00;
			wData_r <= 32'h00000000;
			wStrb_r <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld_r <= 1'b1;
				awAddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld_r <= 1'b1;
				wData_r <= s_axi_wdata;
				wStrb_r <= s_axi_wstrb;
			end
			if (doWrite) begin
				awHeld_r <= 1'b0;
				wHeld_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (awAddr_r <= `DATS_REG_STATUS && awAddr_r[1:0] == 2'h0) ?
					2'h0 : 2'h2;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_r <= `DATS_CTRL_RST;
			zeroSpeedLvl_r <= `DATS_ZSPEED_RST;
			stallCurLvl_r <= `DATS_STALLI_RST;
			stallDelay_r <= `DATS_STALLT_RST;
			supply_rated_volts_r <= `DATS_RATEDV_RST;
		end else if (doWrite) begin
			unique case (awAddr_r)
				`DATS_REG_CTRL: if (wStrb_r[0]) ctrl_r <= wData_r[5:0];
				`DATS_REG_ZSPEED: zeroSpeedLvl_r <= merge16(zeroSpeedLvl_r, wData_r, wStrb_r);
				`DATS_REG_STALLI: stallCurLvl_r <= merge16(stallCurLvl_r, wData_r, wStrb_r);
				`DATS_REG_STALLT: stallDelay_r <= merge16(stallDelay_r, wData_r, wStrb_r);
				`DATS_REG_RATEDV: begin
					supply_rated_volts_r <= merge16(supply_rated_volts_r, wData_r, wStrb_r);
				end
				default: ;
			endcase
		end
	end

	// AXI4-Lite read channel
	assign s_axi_arready = !s_axi_rvalid;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= 2'h0;
			unique case (s_axi_araddr)
				`DATS_REG_CTRL: s_axi_rdata <= {26'h0, ctrl_r};
				`DATS_REG_CLEAR: s_axi_rdata <= 32'h00000000;
				`DATS_REG_ZSPEED: s_axi_rdata <= {16'h0, zeroSpeedLvl_r};
				`DATS_REG_STALLI: s_axi_rdata <= {16'h0, stallCurLvl_r};
				`DATS_REG_STALLT: s_axi_rdata <= {16'h0, stallDelay_r};
				`DATS_REG_RATEDV: s_axi_rdata <= {16'h0, supply_rated_volts_r};
				`DATS_REG_STATUS: begin
					s_axi_rdata <= {10'h0, runActive, syncAcquired, 2'h0, alarmCond,
						cause_r, 3'h0, trip_r};
				end
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= 2'h2;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Millisecond time base
	assign msTick = (tickCnt_r == 32'(MS_TICK_CYCLES - 1));
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) tickCnt_r <= 32'h00000000;
		else tickCnt_r <= msTick ? 32'h00000000 : tickCnt_r + 32'h00000001;
	end

	// Supply synchronisation
	assign freqInRange = supplyPresent && supplyFreqHz >= `DATS_FREQ_MIN &&
		supplyFreqHz <= `DATS_FREQ_MAX;
	assign syncAcquired = (syncCnt_r >= `DATS_SYNC_MS);
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) syncCnt_r <= 16'h0000;
		else if (!freqInRange) syncCnt_r <= 16'h0000;
		else if (msTick && !syncAcquired) syncCnt_r <= syncCnt_r + 16'h0001;
	end

	// Condition qualification
	assign anyShort = |doutShort || userSupplyShort;
	assign lossLimit = 18'({supply_rated_volts_r, 1'b0}) + 18'(supply_rated_volts_r);
	assign lossLive = ({el1Volts, 2'b00} < lossLimit) || ({el2Volts, 2'b00} < lossLimit);
	assign lossAny = lossLive || ({el3Volts, 2'b00} < lossLimit);
	assign zeroRefViolation = zeroRefStartEn && extRefNonzero;
	assign userAlarmIn = (userAlarmSel && userAlarmPin) ||
		(netCardPresent && netWatchdogTimeout);

	always_comb begin
		alarmCond[dats_pkg::AL_STALL] = rotorSpeed < zeroSpeedLvl_r &&
			statorCurrent > stallCurLvl_r;
		alarmCond[dats_pkg::AL_THERM] = thermOhms > `DATS_THERM_OHMS;
		alarmCond[dats_pkg::AL_SINK] = |sinkHot ||
			(largeFrame && fanVolts < `DATS_FAN_VOLTS);
		alarmCond[dats_pkg::AL_SHORT] = anyShort;
		alarmCond[dats_pkg::AL_REF] = refDataInvalid && ref_share_receiver_mode;
		alarmCond[dats_pkg::AL_LOCK] = startRequest && runState_r == dats_pkg::RS_IDLE &&
			(!syncAcquired || zeroRefViolation);
		alarmCond[dats_pkg::AL_USER] = userAlarmIn;
		alarmCond[dats_pkg::AL_SYNC] = runState_r != dats_pkg::RS_IDLE && !syncAcquired;
		alarmCond[dats_pkg::AL_RIDE] = runState_r == dats_pkg::RS_RUN && lossLive;
		alarmCond[dats_pkg::AL_LOSSST] = runState_r == dats_pkg::RS_LOSS_START;
		alarmDelay[dats_pkg::AL_STALL] = stallDelay_r;
		alarmDelay[dats_pkg::AL_THERM] = `DATS_THERM_MS;
		alarmDelay[dats_pkg::AL_SINK] = `DATS_SINK_MS;
		alarmDelay[dats_pkg::AL_SHORT] = 16'h0000;
		alarmDelay[dats_pkg::AL_REF] = `DATS_REF_MS;
		alarmDelay[dats_pkg::AL_LOCK] = `DATS_LOCK_MS;
		alarmDelay[dats_pkg::AL_USER] = `DATS_USER_MS;
		alarmDelay[dats_pkg::AL_SYNC] = 16'h0000;
		alarmDelay[dats_pkg::AL_RIDE] = `DATS_RIDE_MS;
		alarmDelay[dats_pkg::AL_LOSSST] = `DATS_LOCK_MS;
		alarmEnabled = {NAL{1'b1}};
		alarmEnabled[dats_pkg::AL_SHORT] = output_short_trip_en;
		alarmEnabled[dats_pkg::AL_REF] = refTripEn;
	end

	// Per-alarm delay timers
	for (genvar i = 0; i < NAL; i++) begin : g_timer
		assign alarmExpired[i] = alarmCond[i] && timerCnt_r[i] >= alarmDelay[i];
		always_ff @(posedge clk or negedge resetn) begin
			if (!resetn) timerCnt_r[i] <= 16'h0000;
			else if (!alarmCond[i]) timerCnt_r[i] <= 16'h0000;
			else if (msTick && !alarmExpired[i]) timerCnt_r[i] <= timerCnt_r[i] + 16'h0001;
		end
		AST_TIMER_RESTART: assert property (@(posedge clk) disable iff (!resetn)
			!alarmCond[i] |=> timerCnt_r[i] == 16'h0000)
			else $error("alarm timer not restarted");
	end

	// Trip latch with cause, lowest index wins
	assign fire = alarmExpired & alarmEnabled;
	always_comb begin
		cause_nxt = 4'h0;
		for (int k = NAL - 1; k >= 0; k--) begin
			if (fire[k]) cause_nxt = 4'(k);
		end
	end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			trip_r <= 1'b0;
			cause_r <= 4'h0;
		end else if (!trip_r && |fire) begin
			trip_r <= 1'b1;
			cause_r <= cause_nxt;
		end else if (trip_r && clearReq && !(|fire)) begin
			trip_r <= 1'b0;
		end
	end

	// Run control
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) runState_r <= dats_pkg::RS_IDLE;
		else begin
			unique case (runState_r)
				dats_pkg::RS_IDLE: begin
					if (startRequest && !trip_r && syncAcquired && !zeroRefViolation) begin
						runState_r <= lossAny ? dats_pkg::RS_LOSS_START : dats_pkg::RS_RUN;
					end
				end
				dats_pkg::RS_RUN, dats_pkg::RS_LOSS_START: begin
					if (!startRequest || trip_r) runState_r <= dats_pkg::RS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			doutDrive <= 7'h00;
			currentInhibit <= 1'b1;
			contactorOn <= 1'b0;
			runActive <= 1'b0;
		end else begin
			doutDrive <= anyShort ? 7'h00 : doutRequest;
			currentInhibit <= trip_r || runState_r != dats_pkg::RS_RUN ||
				lossLive;
			contactorOn <= runState_r != dats_pkg::RS_IDLE && !trip_r;
			runActive <= runState_r == dats_pkg::RS_RUN;
		end
	end
	assign tripOut = trip_r;
	assign tripCause = cause_r;

	sequence seqRefusedStart;
		runState_r == dats_pkg::RS_IDLE && startRequest && zeroRefViolation;
	endsequence
	sequence seqTripHeld;
		trip_r && !clearReq;
	endsequence

	AST_SHORT_OUTS: assert property (@(posedge clk) disable iff (!resetn)
		anyShort |=> doutDrive == 7'h00)
		else $error("outputs not forced low on short");
	AST_TRIP_LATCH: assert property (@(posedge clk) disable iff (!resetn)
		seqTripHeld |=> trip_r && $stable(cause_r))
		else $error("trip or cause not held");
	AST_SHORT_DISABLED: assert property (@(posedge clk) disable iff (!resetn)
		!trip_r && !output_short_trip_en && fire == 10'h000 |=> !trip_r)
		else $error("trip with nothing enabled firing");
	AST_REF_MODE: assert property (@(posedge clk) disable iff (!resetn)
		!ref_share_receiver_mode |-> !alarmCond[dats_pkg::AL_REF])
		else $error("bad reference evaluated outside receiver role");
	AST_REF_GATE: assert property (@(posedge clk) disable iff (!resetn)
		!trip_r && !refTripEn && alarmExpired == 10'h010 |=> !trip_r)
		else $error("disabled bad reference tripped");
	AST_ZERO_REF: assert property (@(posedge clk) disable iff (!resetn)
		seqRefusedStart |=> runState_r == dats_pkg::RS_IDLE)
		else $error("start accepted against zero reference interlock");
	AST_LOSS_INHIBIT: assert property (@(posedge clk) disable iff (!resetn)
		runState_r == dats_pkg::RS_RUN && lossLive |=> currentInhibit)
		else $error("current not inhibited during supply loss");
	AST_THERM_COND: assert property (@(posedge clk) disable iff (!resetn)
		thermOhms > `DATS_THERM_OHMS |-> alarmCond[dats_pkg::AL_THERM])
		else $error("thermistor condition missed");
	AST_LOSS_START: assert property (@(posedge clk) disable iff (!resetn)
		runState_r == dats_pkg::RS_LOSS_START && !trip_r && startRequest
		|=> contactorOn && currentInhibit)
		else $error("loss at start not handled");
endmodule // dats_supervisor

// ---- common/dats_cfg.svh ----
/*
 Offsets, field positions, reset values and timing counts of the trip supervisor.
 Assumes inclusion by the supervisor top module and its testbench only.
*/
`ifndef DATS_CFG_SVH
`define DATS_CFG_SVH
`define DATS_CLK_HZ        20000000
`define DATS_CLK_PERIOD_NS 50
`define DATS_TICK_US       1000
`define DATS_THERM_MS      16'h3A98
`define DATS_SINK_MS       16'h02EE
`define DATS_REF_MS        16'h05DC
`define DATS_LOCK_MS       16'h0BB8
`define DATS_USER_MS       16'h01F4
`define DATS_SYNC_MS       16'h02EE
`define DATS_RIDE_MS       16'h07D0
`define DATS_THERM_OHMS    16'h0708
`define DATS_FAN_VOLTS     16'h0096
`define DATS_FREQ_MIN      8'h2D
`define DATS_FREQ_MAX      8'h41
`define DATS_REG_CTRL      8'h00
`define DATS_REG_CLEAR     8'h04
`define DATS_REG_ZSPEED    8'h08
`define DATS_REG_STALLI    8'h0C
`define DATS_REG_STALLT    8'h10
`define DATS_REG_RATEDV    8'h14
`define DATS_REG_STATUS    8'h18
`define DATS_CTRL_SHORT    0
`define DATS_CTRL_REF      1
`define DATS_CTRL_ZREF     2
`define DATS_CTRL_USER     3
`define DATS_CTRL_ROLE     4
`define DATS_CTRL_RST      6'h01
`define DATS_ROLE_RECV     2'h2
`define DATS_ZSPEED_RST    16'h0000
`define DATS_STALLI_RST    16'hFFFF
`define DATS_STALLT_RST    16'h03E8
`define DATS_RATEDV_RST    16'h0000
`define DATS_ST_CAUSE      4
`define DATS_ST_LIVE       8
`define DATS_ST_SYNC       20
`define DATS_ST_RUN        21
`endif

// ---- common/dats_pkg.sv ----
/*
 Types of the trip supervisor: alarm indices and run states.
 Assumes nothing beyond the supervisor top module.
*/
package dats_pkg;
	typedef enum logic [3:0] {
		AL_STALL, AL_THERM, AL_SINK, AL_SHORT, AL_REF,
		AL_LOCK, AL_USER, AL_SYNC, AL_RIDE, AL_LOSSST
	} alarm_type;
	typedef enum logic [1:0] {RS_IDLE, RS_RUN, RS_LOSS_START} run_type;
endpackage

// ---- verification/dats_front_model.sv ----
/*
 Sensing front end model: rotor, stator, thermistor, fan and supply phase levels.
 Assumes the bench picks faults bit by bit and thresholds equal the supervisor registers.
*/
`timescale 1ns/100ps
module dats_front_model #(
	parameter logic [15:0] SPD_LVL = 16'h0064,
	parameter logic [15:0] CUR_LVL = 16'h01F4,
	parameter logic [15:0] RATED   = 16'h0190
) (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic [7:0]  faultSel,
	output logic [15:0]      rotorSpeed,
	output logic [15:0]      statorCurrent,
	output logic [15:0]      thermOhms,
	output logic [15:0]      fanVolts,
	output logic             supplyPresent,
	output logic [7:0]       supplyFreqHz,
	output logic [15:0]      el1Volts,
	output logic [15:0]      el2Volts,
	output logic [15:0]      el3Volts
);
	localparam logic [15:0] EDGE_V = RATED * 16'h0003 / 16'h0004;
	logic [7:0] fault_r;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			fault_r <= 8'h00;
		else
			fault_r <= faultSel;
	end
	// Healthy values sit exactly on each threshold
	assign rotorSpeed = fault_r[0] ? SPD_LVL - 16'h0001 : SPD_LVL;
	assign statorCurrent = fault_r[0] ? CUR_LVL + 16'h0001 : CUR_LVL;
	assign thermOhms = fault_r[1] ? 16'h0709 : 16'h0708;
	assign fanVolts = fault_r[2] ? 16'h0095 : 16'h0096;
	assign supplyFreqHz = fault_r[3] ? 8'h42 : 8'h41;
	assign supplyPresent = !fault_r[4];
	assign el1Volts = fault_r[5] ? EDGE_V - 16'h0001 : EDGE_V;
	assign el2Volts = fault_r[6] ? EDGE_V - 16'h0001 : EDGE_V;
	assign el3Volts = fault_r[7] ? EDGE_V - 16'h0001 : EDGE_V;
endmodule // dats_front_model

// ---- verification/dats_supervisor_tb.sv ----
/*
 Self-checking bench of the trip supervisor with AXI4-Lite master tasks.
 Assumes the front end model and a shortened millisecond tick.
*/
`timescale 1ns/100ps
`include "dats_cfg.svh"
module dats_supervisor_tb;
	localparam int TK = 2;
	logic        clk, resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
	logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        s_axi_rvalid, largeFrame, userSupplyShort, refDataInvalid, startRequest;
	logic        extRefNonzero, userAlarmPin, netCardPresent, netWatchdogTimeout;
	logic        supplyPresent, tripOut, currentInhibit, contactorOn, runActive;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, supplyFreqHz, fault;
	logic [31:0] s_axi_wdata, s_axi_rdata, dat;
	logic [3:0]  s_axi_wstrb, tripCause;
	logic [1:0]  s_axi_bresp, s_axi_rresp, sinkHot, rsp;
	logic [15:0] rotorSpeed, statorCurrent, thermOhms, fanVolts, el1Volts, el2Volts, el3Volts;
	logic [6:0]  doutShort, doutRequest, doutDrive;
	int          fails, n_tests, v;

	dats_supervisor #(.MS_TICK_CYCLES(TK)) i_dats_supervisor (.clk, .resetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .rotorSpeed, .statorCurrent, .thermOhms, .sinkHot, .largeFrame,
		.fanVolts, .doutShort, .userSupplyShort, .doutRequest, .refDataInvalid,
		.startRequest, .extRefNonzero, .userAlarmPin, .netCardPresent, .netWatchdogTimeout,
		.supplyPresent, .supplyFreqHz, .el1Volts, .el2Volts, .el3Volts, .doutDrive,
		.tripOut, .tripCause, .currentInhibit, .contactorOn, .runActive);
	dats_front_model i_dats_front_model (.clk, .resetn, .faultSel(fault), .rotorSpeed,
		.statorCurrent, .thermOhms, .fanVolts, .supplyPresent, .supplyFreqHz, .el1Volts,
		.el2Volts, .el3Volts);

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask

	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic ms(input int n);
		repeat (n * TK) @(posedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ta, tw, tb;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		tb = 1'b0;
		while (!tb) begin
			@(negedge clk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			tb = s_axi_bvalid === 1'b1;
			r = s_axi_bresp;
			@(posedge clk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			if (tb) s_axi_bready <= 1'b0;
		end
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ta, tr;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		tr = 1'b0;
		while (!tr) begin
			@(negedge clk);
			ta = s_axi_arvalid && s_axi_arready;
			tr = s_axi_rvalid === 1'b1;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge clk);
			if (ta) s_axi_arvalid <= 1'b0;
			if (tr) s_axi_rready <= 1'b0;
		end
	endtask

	task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
		rd(a, dat, rsp);
		chk(n, e, dat);
	endtask

	task automatic exp_trip(input logic [3:0] c, input int d);
		int n;
		if (d > 1) begin
			ms(d - 1);
			@(negedge clk);
			chk("early trip", 0, tripOut);
		end
		n = 0;
		while (tripOut !== 1'b1 && n < 3 * TK + 9) begin
			@(negedge clk);
			n++;
		end
		chk("trip", 1, tripOut);
		chk("cause", c, tripCause);
	endtask

	task automatic clr(input int w);
		@(posedge clk);
		fault <= 8'h00;
		{sinkHot, doutShort, userSupplyShort, refDataInvalid, startRequest} <= '0;
		{extRefNonzero, userAlarmPin, netWatchdogTimeout, netCardPresent} <= '0;
		ms(2 + w);
		wr(`DATS_REG_CLEAR, 32'h1, rsp);
		@(negedge clk);
		chk("cleared", 0, tripOut);
	endtask

	initial begin
		repeat (100000) @(posedge clk);
		fails++;
		stop_test;
	end

	initial begin
		{resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, fault, sinkHot, largeFrame} = '0;
		{doutShort, doutRequest, userSupplyShort, refDataInvalid, startRequest} = '0;
		{extRefNonzero, userAlarmPin, netCardPresent, netWatchdogTimeout} = '0;
		s_axi_wstrb = 4'hF;
		fails = 0;
		n_tests = 0;
		v = $urandom(32'h3275);
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		ms(740);
		rd(`DATS_REG_STATUS, dat, rsp);
		chk("sync early", 0, dat[`DATS_ST_SYNC]);
		ms(15);
		rd(`DATS_REG_STATUS, dat, rsp);
		chk("sync", 1, dat[`DATS_ST_SYNC]);
		rdchk("ctrl", `DATS_REG_CTRL, `DATS_CTRL_RST);
		rdchk("stall i", `DATS_REG_STALLI, `DATS_STALLI_RST);
		rdchk("stall t", `DATS_REG_STALLT, `DATS_STALLT_RST);
		rd(8'h1C, dat, rsp);
		chk("rd resp", 2, rsp);
		wr(8'h1C, 32'h0, rsp);
		chk("wr resp", 2, rsp);
		wr(`DATS_REG_ZSPEED, 32'h64, rsp);
		wr(`DATS_REG_STALLI, 32'h1F4, rsp);
		wr(`DATS_REG_STALLT, 32'h32, rsp);
		wr(`DATS_REG_RATEDV, 32'h190, rsp);
		rdchk("stall t wr", `DATS_REG_STALLT, 32'h32);
		fault <= 8'h02;
		exp_trip(dats_pkg::AL_THERM, 15000);
		clr(0);
		fault <= 8'h01;
		exp_trip(dats_pkg::AL_STALL, 50);
		clr(0);
		fault <= 8'h04;
		ms(800);
		chk("small frame fan", 0, tripOut);
		largeFrame <= 1'b1;
		exp_trip(dats_pkg::AL_SINK, 750);
		clr(0);
		sinkHot <= 2'h1 << ($urandom % 2);
		exp_trip(dats_pkg::AL_SINK, 750);
		clr(0);
		doutRequest <= 7'($urandom);
		ms(1);
		chk("dout pass", doutRequest, doutDrive);
		@(posedge clk);
		doutShort <= 7'h1 << ($urandom % 7);
		exp_trip(dats_pkg::AL_SHORT, 0);
		chk("dout low", 0, doutDrive);
		clr(0);
		wr(`DATS_REG_CTRL, 32'h0, rsp);
		userSupplyShort <= 1'b1;
		ms(2);
		chk("dout low 24", 0, doutDrive);
		chk("short off", 0, tripOut);
		rd(`DATS_REG_STATUS, dat, rsp);
		chk("short live", 1, dat[`DATS_ST_LIVE + 3]);
		clr(0);
		wr(`DATS_REG_CTRL, 32'h3, rsp);
		refDataInvalid <= 1'b1;
		ms(1600);
		chk("ref role", 0, tripOut);
		wr(`DATS_REG_CTRL, 32'h21, rsp);
		ms(1600);
		chk("ref off", 0, tripOut);
		refDataInvalid <= 1'b0;
		wr(`DATS_REG_CTRL, 32'h23, rsp);
		refDataInvalid <= 1'b1;
		exp_trip(dats_pkg::AL_REF, 1500);
		clr(0);
		wr(`DATS_REG_CTRL, 32'h1, rsp);
		userAlarmPin <= 1'b1;
		ms(600);
		chk("user open", 0, tripOut);
		wr(`DATS_REG_CTRL, 32'h9, rsp);
		exp_trip(dats_pkg::AL_USER, 500);
		doutShort <= 7'h01;
		ms(2);
		chk("cause held", dats_pkg::AL_USER, tripCause);
		clr(0);
		{netCardPresent, netWatchdogTimeout} <= 2'h3;
		exp_trip(dats_pkg::AL_USER, 500);
		clr(0);
		wr(`DATS_REG_CTRL, 32'h1, rsp);
		startRequest <= 1'b1;
		ms(2);
		chk("run", 7'h6, {runActive, contactorOn, currentInhibit});
		fault <= 8'h80;
		ms(2100);
		chk("el3 run", 0, tripOut);
		fault <= 8'h40;
		ms(1500);
		chk("inhibit", 1, currentInhibit);
		fault <= 8'h00;
		ms(5);
		chk("resume", 7'h6, {runActive, contactorOn, currentInhibit});
		fault <= 8'h20;
		exp_trip(dats_pkg::AL_RIDE, 2000);
		clr(0);
		startRequest <= 1'b1;
		ms(2);
		fault <= 8'h08;
		exp_trip(dats_pkg::AL_SYNC, 0);
		clr(800);
		fault <= 8'h10;
		ms(2);
		startRequest <= 1'b1;
		exp_trip(dats_pkg::AL_LOCK, 3000);
		clr(800);
		wr(`DATS_REG_CTRL, 32'h5, rsp);
		{extRefNonzero, startRequest} <= 2'h3;
		ms(2);
		chk("zero ref", 0, runActive);
		exp_trip(dats_pkg::AL_LOCK, 3000 - 2);
		clr(0);
		wr(`DATS_REG_CTRL, 32'h1, rsp);
		fault <= 8'h80;
		ms(2);
		startRequest <= 1'b1;
		ms(2);
		chk("loss start", 2'h3, {contactorOn, currentInhibit});
		exp_trip(dats_pkg::AL_LOSSST, 3000 - 2);
		clr(0);
		stop_test;
	end
endmodule // dats_supervisor_tb
